// ### hw/diagnostic_keypad_monitor.sv
// Keypad command interpreter and four-character display driver
`timescale 1ns/1ps
`default_nettype none
module diagnostic_keypad_monitor #(
    parameter int unsigned FLASH_HALF = keypad_monitor_pkg::FLASH_HALF_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Keypad pins
    input  wire logic        key_down_i,
    input  wire logic [4:0]  key_code_i,
    // Unit status
    input  wire logic        online_i,
    input  wire logic        mach_check_i,
    input  wire logic [11:0] mach_fault_i,
    // Controller memory bus
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic [15:0]      mem_addr_o,
    output logic [7:0]       mem_wdata_o,
    input  wire logic        mem_ack_i,
    input  wire logic [7:0]  mem_rdata_i,
    // Routine launcher
    output logic             diag_start_o,
    output logic             diag_abort_o,
    output logic [7:0]       diag_id_o,
    input  wire logic        diag_done_i,
    input  wire logic        diag_fail_i,
    input  wire logic [11:0] diag_fault_i,
    // Display, position 3 leftmost
    output logic [19:0]      disp_o
);
    // ----------------------------------------------------------------
    // Types and helpers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_SHOW, S_DATA, S_BYTE, S_ID, S_MEM, S_PROBE
    } panel_e;

    // Digits beyond n are blank; a bare prompt shows w question marks
    function automatic logic [19:0] hex_view(input logic [15:0] v,
                                             input logic [2:0]  n,
                                             input logic [2:0]  w);
        logic [19:0] r;
        r = {4{keypad_monitor_pkg::CH_BLANK}};
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < n) begin
                r[5*i+:5] = {1'b0, v[4*i+:4]};
            end else if (n == 3'd0 && 3'(i) < w) begin
                r[5*i+:5] = keypad_monitor_pkg::CH_QUERY;
            end
        end
        return r;
    endfunction : hex_view

    function automatic logic [19:0] fault_view(input logic [11:0] f);
        return {keypad_monitor_pkg::CH_BLANK, 1'b0, f[11:8], 1'b0, f[7:4],
                1'b0, f[3:0]};
    endfunction : fault_view

    function automatic logic read_fn(input logic [4:0] c);
        return !c[4] || c == keypad_monitor_pkg::KEY_ENTER
            || c == keypad_monitor_pkg::KEY_CLEAR
            || c == keypad_monitor_pkg::KEY_RESET
            || c == keypad_monitor_pkg::KEY_SELECT
            || c == keypad_monitor_pkg::KEY_WATCH
            || c == keypad_monitor_pkg::KEY_SHOW_LOCATION;
    endfunction : read_fn

    localparam logic [2:0] AW = 3'(keypad_monitor_pkg::ADDR_DIGITS);
    localparam logic [2:0] BW = 3'(keypad_monitor_pkg::BYTE_DIGITS);

    // ----------------------------------------------------------------
    // Keypad input and flash timing
    // ----------------------------------------------------------------
    logic [5:0]  key_s;
    logic        held_q;
    logic        press;
    logic [4:0]  code;
    logic        flash_tick;
    logic        flash_on;

    keypad_sync #(.W(6)) u_sync (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .raw_i    ({key_down_i, key_code_i}),
        .stable_o (key_s)
    );

    flash_divider #(.HALF(FLASH_HALF)) u_flash (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .tick_o  (flash_tick),
        .phase_o (flash_on)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            held_q <= 1'b0;
        end else begin
            held_q <= key_s[5];
        end
    end

    assign press = key_s[5] && !held_q;
    assign code  = key_s[4:0];

    // ----------------------------------------------------------------
    // Panel state
    // ----------------------------------------------------------------
    panel_e      st_q;
    logic [15:0] entry_q;
    logic [2:0]  cnt_q;
    logic [15:0] cur_addr_q;
    logic [7:0]  data_q;
    logic        probe_q;
    logic        run_q;
    logic        err_q;
    logic [11:0] fault_q;
    logic [7:0]  id_q;
    logic        start_q;
    logic        abort_q;
    logic        req_q;
    logic        we_q;
    logic [15:0] maddr_q;
    logic [7:0]  wdata_q;
    logic        acc;
    logic [15:0] next_addr;
    logic [15:0] enter_addr;
    logic [2:0]  cap;
    logic        quit_q;
    logic        quit;

    assign acc = press && !online_i && !mach_check_i
              && (!run_q || read_fn(code));
    assign next_addr  = cur_addr_q + 16'h0001;
    assign enter_addr = (cnt_q == 3'd0) ? cur_addr_q : entry_q;
    assign cap        = (st_q == S_ADDR) ? AW : BW;
    assign quit       = acc && code == keypad_monitor_pkg::KEY_CLEAR && probe_q;

    // Address store is reset only by power-on reset, never by routines
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q       <= S_IDLE;
            entry_q    <= 16'h0000;
            cnt_q      <= 3'd0;
            cur_addr_q <= keypad_monitor_pkg::ADDR_RESET;
            data_q     <= 8'h00;
            probe_q    <= 1'b0;
            run_q      <= 1'b0;
            err_q      <= 1'b0;
            fault_q    <= 12'h000;
            id_q       <= 8'h00;
            start_q    <= 1'b0;
            abort_q    <= 1'b0;
            req_q      <= 1'b0;
            we_q       <= 1'b0;
            maddr_q    <= 16'h0000;
            wdata_q    <= 8'h00;
            quit_q     <= 1'b0;
        end else begin
            start_q <= 1'b0;
            abort_q <= 1'b0;
            // A clear during a watch read must not be lost to the bus wait
            if (quit && st_q == S_MEM) begin
                quit_q <= 1'b1;
            end
            if (run_q && diag_done_i) begin
                run_q   <= 1'b0;
                err_q   <= diag_fail_i;
                fault_q <= diag_fault_i;
                if (st_q != S_MEM) begin
                    st_q <= S_IDLE;
                end
            end
            if (acc && code == keypad_monitor_pkg::KEY_RESET) begin
                st_q  <= S_IDLE;
                err_q <= 1'b0;
                cnt_q <= 3'd0;
                req_q <= 1'b0;
                we_q  <= 1'b0;
                quit_q <= 1'b0;
                if (run_q) begin
                    run_q   <= 1'b0;
                    abort_q <= 1'b1;
                end
            end else if (acc && st_q != S_MEM) begin
                if (code[4] && code != keypad_monitor_pkg::KEY_ENTER
                        && code != keypad_monitor_pkg::KEY_CLEAR) begin
                    err_q <= 1'b0;
                end
                case (code)
                    keypad_monitor_pkg::KEY_SELECT,
                    keypad_monitor_pkg::KEY_WATCH: begin
                        st_q    <= S_ADDR;
                        probe_q <= (code == keypad_monitor_pkg::KEY_WATCH);
                        cnt_q   <= 3'd0;
                        entry_q <= 16'h0000;
                    end
                    keypad_monitor_pkg::KEY_SHOW_LOCATION: begin
                        st_q    <= S_SHOW;
                        probe_q <= 1'b0;
                    end
                    keypad_monitor_pkg::KEY_WRITE_BYTE: begin
                        if (st_q == S_DATA && !run_q) begin
                            st_q    <= S_BYTE;
                            cnt_q   <= 3'd0;
                            entry_q <= 16'h0000;
                        end
                    end
                    keypad_monitor_pkg::KEY_RUN_ROUTINE: begin
                        st_q    <= S_ID;
                        cnt_q   <= 3'd0;
                        entry_q <= 16'h0000;
                    end
                    keypad_monitor_pkg::KEY_CLEAR: begin
                        if ((st_q == S_ADDR || st_q == S_BYTE || st_q == S_ID)
                                && cnt_q != 3'd0) begin
                            cnt_q   <= 3'd0;
                            entry_q <= 16'h0000;
                        end else begin
                            st_q <= S_IDLE;
                        end
                    end
                    keypad_monitor_pkg::KEY_ENTER: begin
                        case (st_q)
                            S_ADDR: begin
                                cur_addr_q <= enter_addr;
                                maddr_q    <= enter_addr;
                                req_q      <= 1'b1;
                                st_q       <= S_MEM;
                            end
                            S_SHOW: begin
                                maddr_q <= cur_addr_q;
                                req_q   <= 1'b1;
                                st_q    <= S_MEM;
                            end
                            S_DATA: begin
                                cur_addr_q <= next_addr;
                                maddr_q    <= next_addr;
                                req_q      <= 1'b1;
                                st_q       <= S_MEM;
                            end
                            S_BYTE: begin
                                if (cnt_q != 3'd0) begin
                                    maddr_q <= cur_addr_q;
                                    wdata_q <= entry_q[7:0];
                                    we_q    <= 1'b1;
                                    req_q   <= 1'b1;
                                    st_q    <= S_MEM;
                                end
                            end
                            S_ID: begin
                                if (cnt_q != 3'd0) begin
                                    id_q    <= entry_q[7:0];
                                    start_q <= 1'b1;
                                    run_q   <= 1'b1;
                                    st_q    <= S_IDLE;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                    default: begin
                        if (!code[4] && (st_q == S_ADDR || st_q == S_BYTE
                                || st_q == S_ID)) begin
                            entry_q <= {entry_q[11:0], code[3:0]};
                            if (cnt_q < cap) begin
                                cnt_q <= cnt_q + 3'd1;
                            end
                        end
                    end
                endcase
            end else if (st_q == S_MEM && mem_ack_i) begin
                if (we_q) begin
                    we_q <= 1'b0;
                end else begin
                    req_q  <= 1'b0;
                    data_q <= mem_rdata_i;
                    st_q   <= !probe_q ? S_DATA : (quit || quit_q) ? S_IDLE : S_PROBE;
                    quit_q <= 1'b0;
                end
            end else if (st_q == S_PROBE && flash_tick) begin
                maddr_q <= cur_addr_q;
                req_q   <= 1'b1;
                st_q    <= S_MEM;
            end
        end
    end

    // ----------------------------------------------------------------
    // Display
    // ----------------------------------------------------------------
    logic [19:0] disp_d;
    logic [19:0] disp_q;
    logic [19:0] data_view;

    assign data_view = hex_view({8'h00, data_q}, BW, BW);

    always_comb begin
        disp_d = {4{keypad_monitor_pkg::CH_BLANK}};
        if (online_i) begin
            disp_d = {4{keypad_monitor_pkg::CH_BLANK}};
        end else if (mach_check_i) begin
            disp_d = fault_view(mach_fault_i);
        end else if (held_q) begin
            disp_d = {4{keypad_monitor_pkg::CH_LIT}};
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (err_q) begin
                        disp_d = fault_view(fault_q);
                    end else if (run_q) begin
                        disp_d = {keypad_monitor_pkg::CH_AT, 1'b0, id_q[7:4],
                                  1'b0, id_q[3:0],
                                  keypad_monitor_pkg::CH_BLANK};
                    end else begin
                        disp_d = {4{keypad_monitor_pkg::CH_DASH}};
                    end
                end
                S_ADDR:  disp_d = hex_view(entry_q, cnt_q, AW);
                S_SHOW:  disp_d = hex_view(cur_addr_q, AW, AW);
                S_BYTE,
                S_ID:    disp_d = hex_view(entry_q, cnt_q, BW);
                S_PROBE: begin
                    if (flash_on) begin
                        disp_d = data_view;
                    end
                end
                S_DATA,
                S_MEM: begin
                    // Old byte stays up while the bus answers
                    if (!probe_q || flash_on) begin
                        disp_d = data_view;
                    end
                end
                default: disp_d = {4{keypad_monitor_pkg::CH_DASH}};
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            disp_q <= {4{keypad_monitor_pkg::CH_BLANK}};
        end else begin
            disp_q <= disp_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign disp_o       = disp_q;
    assign mem_req_o    = req_q;
    assign mem_we_o     = we_q;
    assign mem_addr_o   = maddr_q;
    assign mem_wdata_o  = wdata_q;
    assign diag_start_o = start_q;
    assign diag_abort_o = abort_q;
    assign diag_id_o    = id_q;

endmodule : diagnostic_keypad_monitor
`default_nettype wire

// ### hw/keypad_monitor_pkg.sv
// Shared constants for the diagnostic keypad monitor
package keypad_monitor_pkg;

    // ----------------------------------------------------------------
    // Key codes: 5'h00..5'h0F are the hex digit keys
    // ----------------------------------------------------------------
    localparam logic [4:0] KEY_ENTER         = 5'h10;
    localparam logic [4:0] KEY_SELECT        = 5'h11;
    localparam logic [4:0] KEY_SHOW_LOCATION = 5'h12;
    localparam logic [4:0] KEY_WRITE_BYTE    = 5'h13;
    localparam logic [4:0] KEY_WATCH         = 5'h14;
    localparam logic [4:0] KEY_RUN_ROUTINE   = 5'h15;
    localparam logic [4:0] KEY_CLEAR         = 5'h16;
    localparam logic [4:0] KEY_RESET         = 5'h17;

    // ----------------------------------------------------------------
    // Display character codes: 5'h00..5'h0F show the hex digit
    // ----------------------------------------------------------------
    localparam logic [4:0] CH_BLANK = 5'h10;
    localparam logic [4:0] CH_QUERY = 5'h11;
    localparam logic [4:0] CH_DASH  = 5'h12;
    localparam logic [4:0] CH_AT    = 5'h13;
    localparam logic [4:0] CH_LIT   = 5'h14;

    // ----------------------------------------------------------------
    // Widths, reset values and timing
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_DIGITS = 4;
    localparam int unsigned BYTE_DIGITS = 2;
    localparam logic [15:0] ADDR_RESET  = 16'h0000;
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned FLASH_HALF_NS  = 50_000_000;
    localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_NS / CLK_PERIOD_NS;

endpackage : keypad_monitor_pkg

// ### hw/keypad_sync.sv
// Three-stage synchroniser for the keypad pins
`timescale 1ns/1ps
`default_nettype none
module keypad_sync #(
    parameter int unsigned W = 6
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Pins and settled levels
    input  wire logic [W-1:0] raw_i,
    output logic      [W-1:0] stable_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] stable_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= raw_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit moves only once stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                stable_q[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                stable_q[i] <= s3_q[i];
            end
        end
    end

    assign stable_o = stable_q;
endmodule : keypad_sync
`default_nettype wire

// ### hw/flash_divider.sv
// Divider giving the flash phase for the watched byte
`timescale 1ns/1ps
`default_nettype none
module flash_divider #(
    parameter int unsigned HALF = 1_250_000
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Enable pulse and phase
    output logic      tick_o,
    output logic      phase_o
);
    localparam int unsigned CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] cnt_q;
    logic          phase_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q   <= '0;
            phase_q <= 1'b1;
        end else if (cnt_q == LAST) begin
            cnt_q   <= '0;
            phase_q <= ~phase_q;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    assign tick_o  = (cnt_q == LAST);
    assign phase_o = phase_q;
endmodule : flash_divider
`default_nettype wire

// ### verif/keypad_monitor_assertions.sv
// Port-level checks for the keypad monitor
`timescale 1ns/1ps
`default_nettype none
module keypad_monitor_assertions (
    // Clock, reset and inputs
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        online_i,
    input wire logic        mach_check_i,
    input wire logic [11:0] mach_fault_i,
    input wire logic        mem_ack_i,
    // Design outputs
    input wire logic        mem_req_o,
    input wire logic        mem_we_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic        diag_start_o,
    input wire logic        diag_abort_o,
    input wire logic [7:0]  diag_id_o,
    input wire logic [19:0] disp_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_online_blank: assert property ($past(online_i) && !$past(mach_check_i) && $past(rst_n_i)
        |-> disp_o == {4{keypad_monitor_pkg::CH_BLANK}}) else $error("display lit while online");
    a_mcheck_fault: assert property ($past(mach_check_i) && !$past(online_i)
        && $past(rst_n_i) |-> disp_o ==
        {keypad_monitor_pkg::CH_BLANK, 1'b0, $past(mach_fault_i[11:8]), 1'b0,
        $past(mach_fault_i[7:4]), 1'b0, $past(mach_fault_i[3:0])}) else $error("no fault code");
    a_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
        && $stable(mem_we_o)) else $error("memory request changed before ack");
    a_write_readback: assert property (mem_req_o && mem_we_o && mem_ack_i |=> mem_req_o
        && !mem_we_o && $stable(mem_addr_o)) else $error("no read-back after write");
    a_read_release: assert property (mem_req_o && !mem_we_o && mem_ack_i |=> !mem_req_o)
        else $error("read request held after ack");
    a_start_pulse: assert property (diag_start_o |=> (!diag_start_o && $stable(diag_id_o)) [*4])
        else $error("start not a single pulse");
    a_abort_pulse: assert property (diag_abort_o |=> !diag_abort_o && !diag_start_o)
        else $error("abort not a single pulse");
    a_run_display: assert property (diag_start_o |-> ##[1:30] disp_o ==
        {keypad_monitor_pkg::CH_AT, 1'b0, diag_id_o[7:4], 1'b0, diag_id_o[3:0],
        keypad_monitor_pkg::CH_BLANK}) else $error("routine id not shown");
    a_online_quiet: assert property (online_i && $past(online_i) |-> !diag_start_o
        && !$rose(mem_req_o)) else $error("activity while online");
endmodule : keypad_monitor_assertions
bind diagnostic_keypad_monitor keypad_monitor_assertions u_keypad_monitor_assertions (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .online_i(online_i), .mach_check_i(mach_check_i),
    .mach_fault_i(mach_fault_i), .mem_ack_i(mem_ack_i), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .diag_start_o(diag_start_o),
    .diag_abort_o(diag_abort_o), .diag_id_o(diag_id_o), .disp_o(disp_o));
`default_nettype wire

// ### verif/keypad_mem_model.sv
// Controller memory seen by the monitor; odd addresses answer late
`timescale 1ns/1ps
`default_nettype none
module keypad_mem_model #(
    parameter logic [15:0] RO_BASE = 16'hf000
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Memory bus
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [7:0]  mem_wdata_i,
    output logic             mem_ack_o,
    output logic [7:0]       mem_rdata_o
);
    logic [7:0] store [logic [15:0]];
    logic [2:0] wait_q;
    function automatic logic [7:0] peek(input logic [15:0] a);
        return store.exists(a) ? store[a] : a[15:8] ^ a[7:0] ^ 8'h5a;
    endfunction : peek
    // Read data toggles off-ack so a stale sample never looks right
    always @(posedge clk_i) begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        wait_q <= wait_q + 3'h1;
        if (!rst_n_i || !mem_req_i || mem_ack_o) begin
            wait_q <= 3'h0;
            if (!rst_n_i) mem_rdata_o <= 8'h00;
        end else if (wait_q == {mem_addr_i[0], 2'b00}) begin
            mem_ack_o <= 1'b1;
            mem_rdata_o <= peek(mem_addr_i);
            if (mem_we_i && mem_addr_i < RO_BASE) store[mem_addr_i] = mem_wdata_i;
        end
    end
endmodule : keypad_mem_model
`default_nettype wire

// ### verif/test_diagnostic_keypad_monitor.sv
// Random and corner-case bench for the keypad monitor
`timescale 1ns/1ps
`default_nettype none
module test_diagnostic_keypad_monitor;
    localparam logic [4:0] B = keypad_monitor_pkg::CH_BLANK, Q = keypad_monitor_pkg::CH_QUERY;
    localparam logic [4:0] D = keypad_monitor_pkg::CH_DASH, A = keypad_monitor_pkg::CH_AT;
    logic clk_i = 0, rst_n = 0, kd = 0, onl = 0, mck = 0, dn = 0, fl = 0, req_q = 0, sd, sb;
    logic [4:0] kc = 0;
    logic [11:0] mf = 0, df = 0;
    logic req, we, ack, st, ab;
    logic [15:0] ma, a, r;
    logic [7:0] wd, rd, id, sid, dt, rid;
    logic [19:0] disp;
    int n_fail = 0, tests_run = 0, n_req = 0, n_ab = 0;
    always #20 clk_i = ~clk_i;
    diagnostic_keypad_monitor #(.FLASH_HALF(8)) u_diagnostic_keypad_monitor (
        .clk_i(clk_i), .rst_n_i(rst_n), .key_down_i(kd), .key_code_i(kc), .online_i(onl),
        .mach_check_i(mck), .mach_fault_i(mf), .mem_req_o(req), .mem_we_o(we),
        .mem_addr_o(ma), .mem_wdata_o(wd), .mem_ack_i(ack), .mem_rdata_i(rd),
        .diag_start_o(st), .diag_abort_o(ab), .diag_id_o(id), .diag_done_i(dn),
        .diag_fail_i(fl), .diag_fault_i(df), .disp_o(disp));
    keypad_mem_model u_keypad_mem_model (.clk_i(clk_i), .rst_n_i(rst_n), .mem_req_i(req),
        .mem_we_i(we), .mem_addr_i(ma), .mem_wdata_i(wd), .mem_ack_o(ack), .mem_rdata_o(rd));
    always @(posedge clk_i) begin
        req_q <= req;
        if (req === 1'b1 && !req_q) n_req++;
        if (st === 1'b1) sid <= id;
        if (ab === 1'b1) n_ab++;
    end
    function automatic logic [19:0] hx(input logic [15:0] v);
        return {1'b0, v[15:12], 1'b0, v[11:8], 1'b0, v[7:4], 1'b0, v[3:0]};
    endfunction : hx
    function automatic logic [19:0] hb(input logic [7:0] v);
        return {B, B, 1'b0, v[7:4], 1'b0, v[3:0]};
    endfunction : hb
    function automatic logic [7:0] f(input logic [15:0] v);
        return v[15:8] ^ v[7:0] ^ 8'h5a;
    endfunction : f
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic press(input logic [4:0] k);
        kc = k;
        tick(2);
        kd = 1;
        tick(8);
        kd = 0;
        tick(10);
    endtask : press
    task automatic entry(input logic [4:0] k, input logic [15:0] v);
        press(k);
        for (int i = 3; i >= 0; i--) press({1'b0, v[i*4 +: 4]});
    endtask : entry
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        tests_run++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk
    task automatic report_and_stop;
        if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        void'($urandom(53915));
        a = $urandom;
        a[15] = 1'b0;
        a[0] = 1'b1;
        dt = $urandom;
        r = a | 16'hf000;
        tick(16);
        rst_n = 1;
        tick(4);
        chk("idle", {D, D, D, D}, disp);
        kc = 5'h05;
        tick(2);
        kd = 1;
        tick(8);
        chk("lit", {4{keypad_monitor_pkg::CH_LIT}}, disp);
        kd = 0;
        tick(10);
        chk("lit released", {D, D, D, D}, disp);
        press(keypad_monitor_pkg::KEY_SHOW_LOCATION);
        chk("start address", hx(16'h0000), disp);
        press(keypad_monitor_pkg::KEY_SELECT);
        chk("address prompt", {Q, Q, Q, Q}, disp);
        entry(5'h0f, a);
        chk("address digits", hx(a), disp);
        press(keypad_monitor_pkg::KEY_ENTER);
        chk("byte", hb(f(a)), disp);
        press(keypad_monitor_pkg::KEY_ENTER);
        chk("next byte", hb(f(a + 16'h1)), disp);
        press(keypad_monitor_pkg::KEY_SELECT);
        press(keypad_monitor_pkg::KEY_ENTER);
        chk("reused address", hb(f(a + 16'h1)), disp);
        press(keypad_monitor_pkg::KEY_WRITE_BYTE);
        chk("byte prompt", {B, B, Q, Q}, disp);
        entry(5'h07, {8'h00, dt});
        press(keypad_monitor_pkg::KEY_ENTER);
        chk("written", hb(dt), disp);
        entry(keypad_monitor_pkg::KEY_SELECT, r);
        press(keypad_monitor_pkg::KEY_ENTER);
        entry(keypad_monitor_pkg::KEY_WRITE_BYTE, {8'h00, ~f(r)});
        press(keypad_monitor_pkg::KEY_ENTER);
        chk("read-only", hb(f(r)), disp);
        press(keypad_monitor_pkg::KEY_SELECT);
        press(5'h03);
        press(keypad_monitor_pkg::KEY_CLEAR);
        chk("cleared entry", {Q, Q, Q, Q}, disp);
        press(keypad_monitor_pkg::KEY_CLEAR);
        chk("cleared prompt", {D, D, D, D}, disp);
        entry(keypad_monitor_pkg::KEY_WATCH, a ^ 16'h1);
        press(keypad_monitor_pkg::KEY_ENTER);
        n_req = 0;
        sd = 0;
        sb = 0;
        repeat (80) begin
            tick(1);
            if (disp === hb(f(a ^ 16'h1))) sd = 1;
            if (disp === {B, B, B, B}) sb = 1;
        end
        chk("watch reads", 20'h1, {19'h0, n_req >= 6});
        chk("flashing", 20'h1, {19'h0, sd && sb});
        press(keypad_monitor_pkg::KEY_CLEAR);
        chk("watch end", {D, D, D, D}, disp);
        press(keypad_monitor_pkg::KEY_SHOW_LOCATION);
        chk("kept address", hx(a ^ 16'h1), disp);
        for (int k = 0; k < 3; k++) begin
            rid = $urandom;
            entry(keypad_monitor_pkg::KEY_RUN_ROUTINE, {8'h00, rid});
            press(keypad_monitor_pkg::KEY_ENTER);
            chk("routine id", {12'h0, rid}, {12'h0, sid});
            press(keypad_monitor_pkg::KEY_WRITE_BYTE);
            chk("busy", {A, 1'b0, rid[7:4], 1'b0, rid[3:0], B}, disp);
            if (k < 2) begin
                df = $urandom;
                fl = (k == 0);
                dn = 1;
                tick(1);
                dn = 0;
                tick(2);
            end else press(keypad_monitor_pkg::KEY_RESET);
            chk("routine end", k ? {D, D, D, D} : {B, 15'(hx({4'h0, df}))}, disp);
        end
        chk("aborts", 20'h1, {19'h0, n_ab == 1});
        onl = 1;
        tick(2);
        n_req = 0;
        press(keypad_monitor_pkg::KEY_SELECT);
        chk("online", {B, B, B, B}, disp);
        onl = 0;
        mck = 1;
        mf = $urandom;
        tick(2);
        press(keypad_monitor_pkg::KEY_SELECT);
        chk("machine check", {B, 15'(hx({4'h0, mf}))}, disp);
        chk("quiet bus", 20'h0, n_req[19:0]);
        mck = 0;
        tick(2);
        chk("keys ignored", {D, D, D, D}, disp);
        report_and_stop();
    end
endmodule : test_diagnostic_keypad_monitor
`default_nettype wire
